// *** verilog/rac_pkg.sv ***
// Shared constants and decoders for the record-path AGC register bank.
package rac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_LEFT_A = 8'h1A; // Left control A
  localparam logic [7:0] ADDR_LEFT_B = 8'h1B; // Left control B
  localparam logic [7:0] ADDR_LEFT_C = 8'h1C; // Left control C
  localparam logic [7:0] ADDR_RIGHT_A = 8'h1D; // Right control A
  localparam logic [7:0] ADDR_RIGHT_B = 8'h1E; // Right control B
  localparam logic [7:0] ADDR_RIGHT_C = 8'h1F; // Right control C
  localparam logic [7:0] ADDR_GAIN_LEFT = 8'h20; // Left applied gain, read only
  localparam logic [7:0] ADDR_GAIN_RIGHT = 8'h21; // Right applied gain, read only
  localparam int NUM_CH = 2; // Left and right channels
  localparam int REGS_PER_CH = 3; // Control A, B, C per channel
  localparam int NUM_CTRL = NUM_CH * REGS_PER_CH; // Writable registers
  localparam logic [7:0] RD_UNMAPPED = 8'h00; // Read value off the map

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_CTRL_A = 8'h00; // Disabled, fastest settings
  localparam logic [7:0] RST_CTRL_B = 8'hFE; // Max gain code all ones
  localparam logic [7:0] RST_CTRL_C = 8'h00; // Gate off, no clip stepping

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int EN_BIT = 7; // Control A enable
  localparam int TGT_MSB = 6; // Control A target level
  localparam int TGT_LSB = 4;
  localparam int ATK_MSB = 3; // Control A attack time
  localparam int ATK_LSB = 2;
  localparam int DEC_MSB = 1; // Control A decay time
  localparam int DEC_LSB = 0;
  localparam int MAXG_MSB = 7; // Control B maximum gain
  localparam int MAXG_LSB = 1;
  localparam int HYS_MSB = 7; // Control C hysteresis
  localparam int HYS_LSB = 6;
  localparam int THR_MSB = 5; // Control C noise threshold
  localparam int THR_LSB = 1;
  localparam int CLIP_BIT = 0; // Control C clip stepping

  ////////////////////////////////////////////////////////////////////////////
  // Gain and level scaling, all in half-dB units
  localparam logic [6:0] MAXG_CAP = 7'h77; // Highest usable max-gain code
  localparam logic signed [7:0] GAIN_MIN = 8'hE8; // Lowest applied gain
  localparam logic signed [7:0] GAIN_ZERO = 8'h00; // Gain while disabled
  localparam logic [4:0] THR_OFF = 5'h00; // Threshold code: gate off
  localparam logic [1:0] HYS_NONE = 2'h3; // Hysteresis code: none
  localparam int THR_BASE_HDB = -60; // Threshold at code one
  localparam int THR_STEP_HDB = 4; // Threshold drop per code
  localparam int HYS_STEP_HDB = 2; // Hysteresis per code
  localparam logic signed [9:0] CLIP_LEVEL_HDB = 10'h000; // Full scale

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 50; // Core clock period
  localparam int NS_PER_MS = 1000000; // Unit conversion
  localparam int CYC_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS; // Cycles per ms
  localparam int TC_STEPS = 16; // Gain steps per time constant
  localparam int DRA_DIV = 2; // Double-rate audio divides step times by this
  localparam int MIN_STEP_CYC = 1; // Shortest step interval in cycles

  // Attack time in ms for a code
  function automatic int atk_ms(input logic [1:0] code);
    unique case (code)
      2'h0: atk_ms = 8;
      2'h1: atk_ms = 11;
      2'h2: atk_ms = 16;
      2'h3: atk_ms = 20;
    endcase
  endfunction

  // Decay time in ms for a code
  function automatic int dec_ms(input logic [1:0] code);
    unique case (code)
      2'h0: dec_ms = 100;
      2'h1: dec_ms = 200;
      2'h2: dec_ms = 400;
      2'h3: dec_ms = 500;
    endcase
  endfunction

  // Output target in half-dB for a code
  function automatic logic signed [9:0] target_hdb(input logic [2:0] code);
    unique case (code)
      3'h0: target_hdb = -10'sd11;
      3'h1: target_hdb = -10'sd16;
      3'h2: target_hdb = -10'sd20;
      3'h3: target_hdb = -10'sd24;
      3'h4: target_hdb = -10'sd28;
      3'h5: target_hdb = -10'sd34;
      3'h6: target_hdb = -10'sd40;
      3'h7: target_hdb = -10'sd48;
    endcase
  endfunction

endpackage

// *** verilog/rac_agc_chan.sv ***
// One AGC channel: noise gate, clip stepping and timed gain tracking.
module rac_agc_chan
  import rac_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] ctrl_a,
  input wire logic [7:0] ctrl_b,
  input wire logic [7:0] ctrl_c,
  input wire logic dra_en,
  input wire logic signed [9:0] level_hdb,
  output logic signed [7:0] gain_hdb,
  output logic sat
);

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  logic en; // Channel enable
  logic signed [7:0] max_eff; // Ceiling in half-dB
  logic signed [10:0] out_hdb; // Level after applied gain, one bit of headroom
  logic signed [9:0] tgt_hdb; // Target level
  logic signed [9:0] thr_hdb; // Noise threshold
  logic signed [9:0] hys_hdb; // Noise gate release margin
  logic gate_on; // Noise detection active
  logic clip_now; // Clip step due this cycle
  logic [23:0] interval; // Cycles per gain step
  logic tick; // Gain step allowed
  logic signed [7:0] gain_q; // Applied gain
  logic noise_q; // Signal below threshold
  logic [23:0] cnt_q; // Step timer
  logic sat_q; // Gain at ceiling

  assign en = ctrl_a[EN_BIT];
  // Codes above the cap all give the cap
  assign max_eff = (ctrl_b[MAXG_MSB:MAXG_LSB] > MAXG_CAP) ?
    $signed({1'b0, MAXG_CAP}) : $signed({1'b0, ctrl_b[MAXG_MSB:MAXG_LSB]});
  // Widened so a hot input plus a high gain cannot wrap and look quiet
  assign out_hdb = 11'(level_hdb) + 11'(gain_q);
  assign tgt_hdb = target_hdb(ctrl_a[TGT_MSB:TGT_LSB]);
  assign gate_on = ctrl_c[THR_MSB:THR_LSB] != THR_OFF;
  assign thr_hdb = 10'(THR_BASE_HDB -
    (int'(ctrl_c[THR_MSB:THR_LSB]) - 1) * THR_STEP_HDB);
  // Code 11 releases at the bare threshold
  assign hys_hdb = (ctrl_c[HYS_MSB:HYS_LSB] == HYS_NONE) ? 10'sd0 :
    10'((int'(ctrl_c[HYS_MSB:HYS_LSB]) + 1) * HYS_STEP_HDB);
  assign clip_now = ctrl_c[CLIP_BIT] && (out_hdb >= CLIP_LEVEL_HDB);

  ////////////////////////////////////////////////////////////////////////////
  // Step interval: attack when loud, decay when quiet
  always_comb
  begin
    int ms;
    int cyc;
    ms = (out_hdb > tgt_hdb) ? atk_ms(ctrl_a[ATK_MSB:ATK_LSB])
                             : dec_ms(ctrl_a[DEC_MSB:DEC_LSB]);
    cyc = ms * (CYC_PER_MS / TC_STEPS);
    // Double-rate audio runs twice the frames, so times halve
    if (dra_en)
    begin
      cyc = cyc / DRA_DIV;
    end
    if (cyc < MIN_STEP_CYC)
    begin
      cyc = MIN_STEP_CYC;
    end
    interval = 24'(cyc);
  end

  assign tick = cnt_q >= (interval - 24'h000001);

  ////////////////////////////////////////////////////////////////////////////
  // Step timer, held clear while disabled
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 24'h000000;
    end
    else if (!en || tick)
    begin
      cnt_q <= 24'h000000;
    end
    else
    begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Noise gate with hysteresis on release
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      noise_q <= 1'b0;
    end
    else if (!gate_on)
    begin
      noise_q <= 1'b0;
    end
    else if (!noise_q && level_hdb < thr_hdb)
    begin
      noise_q <= 1'b1;
    end
    else if (noise_q && level_hdb > thr_hdb + hys_hdb)
    begin
      noise_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied gain; clip stepping bypasses the timer to act at once
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gain_q <= GAIN_ZERO;
    end
    else if (!en)
    begin
      gain_q <= GAIN_ZERO;
    end
    else if (gain_q > max_eff)
    begin
      gain_q <= max_eff;
    end
    else if (clip_now && gain_q > GAIN_MIN)
    begin
      gain_q <= gain_q - 8'sd1;
    end
    else if (noise_q)
    begin
      gain_q <= gain_q; // Silence: no boosting of noise
    end
    else if (tick && out_hdb > tgt_hdb && gain_q > GAIN_MIN)
    begin
      gain_q <= gain_q - 8'sd1;
    end
    else if (tick && out_hdb < tgt_hdb && gain_q < max_eff)
    begin
      gain_q <= gain_q + 8'sd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saturation flag
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sat_q <= 1'b0;
    end
    else
    begin
      sat_q <= en && (gain_q == max_eff);
    end
  end

  assign gain_hdb = gain_q;
  assign sat = sat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet_step;
    en && tick && !noise_q && !clip_now && gain_q <= max_eff;
  endsequence

  chk_disable_zero: assert property (!en |=> gain_q == GAIN_ZERO)
    else $error("gain not zero while disabled");
  chk_gain_ceiling: assert property (en |=> gain_q <= $past(max_eff))
    else $error("gain above ceiling");
  chk_sat_flag: assert property ((en && gain_q == max_eff) |=> sat_q)
    else $error("saturation flag missed");
  chk_gate_off: assert property (!gate_on |=> !noise_q)
    else $error("noise detected with gate off");
  chk_hys_none: assert property ((noise_q && hys_hdb == 10'sd0 && level_hdb > thr_hdb
    && gate_on) |=> !noise_q)
    else $error("gate held past bare threshold");
  chk_clip_step: assert property ((en && clip_now && gain_q > GAIN_MIN
    && gain_q <= max_eff) |=> gain_q == $past(gain_q) - 8'sd1)
    else $error("clip step missing");
  chk_attack_step: assert property ((s_quiet_step and
    (out_hdb > tgt_hdb && gain_q > GAIN_MIN)) |=> gain_q == $past(gain_q) - 8'sd1)
    else $error("attack step missing");
  chk_decay_step: assert property ((s_quiet_step and
    (out_hdb < tgt_hdb && gain_q < max_eff)) |=> gain_q == $past(gain_q) + 8'sd1)
    else $error("decay step missing");

endmodule

// *** verilog/rac_regs.sv ***
// Record AGC control register bank with both channel engines.
module rac_regs
  import rac_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF // Shorten for simulation
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic dra_en,
  input wire logic signed [9:0] level_left_hdb,
  input wire logic signed [9:0] level_right_hdb,
  output logic signed [7:0] gain_left_hdb,
  output logic signed [7:0] gain_right_hdb,
  output logic sat_left,
  output logic sat_right
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Register slot for an address, or NUM_CTRL when not a control register
  // Gain addresses sit above the slot range, so writes never reach them
  function automatic int ctrl_index(input logic [7:0] addr);
    if (addr >= ADDR_LEFT_A && addr <= ADDR_RIGHT_C)
    begin
      ctrl_index = int'(addr - ADDR_LEFT_A);
    end
    else
    begin
      ctrl_index = NUM_CTRL;
    end
  endfunction

  // Reset value of a slot by its position in the channel
  function automatic logic [7:0] ctrl_reset(input int idx);
    unique case (idx % REGS_PER_CH)
      0: ctrl_reset = RST_CTRL_A;
      1: ctrl_reset = RST_CTRL_B;
      default: ctrl_reset = RST_CTRL_C;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assert is immediate
  logic rst_meta_q; // First stage, read only by the second
  logic rst_sync_q; // Internal active-low reset

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, left then right
  logic [7:0] ctrl_q [NUM_CTRL]; // Slot = address minus left A
  logic signed [7:0] gain_w [NUM_CH]; // Applied gain per channel
  logic sat_w [NUM_CH]; // Saturation per channel
  logic [7:0] rdata_q; // Registered read data
  int wr_idx; // Slot hit by the write address

  assign wr_idx = ctrl_index(reg_addr);

  // Every bit stored as written; bit 0 of B is kept as software left it
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      for (int i = 0; i < NUM_CTRL; i++)
      begin
        ctrl_q[i] <= ctrl_reset(i);
      end
    end
    else if (reg_wr && wr_idx < NUM_CTRL)
    begin
      ctrl_q[wr_idx] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the address
  // A read and a write of one slot on the same edge return the old value
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      rdata_q <= RD_UNMAPPED;
    end
    else if (ctrl_index(reg_addr) < NUM_CTRL)
    begin
      rdata_q <= ctrl_q[ctrl_index(reg_addr)];
    end
    else if (reg_addr == ADDR_GAIN_LEFT)
    begin
      rdata_q <= gain_w[0];
    end
    else if (reg_addr == ADDR_GAIN_RIGHT)
    begin
      rdata_q <= gain_w[1];
    end
    else
    begin
      rdata_q <= RD_UNMAPPED; // Off the map reads zero
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Channel engines; each sees only its own three registers
  // Only dra_en is shared, so one channel's settings never move the other
  logic signed [9:0] level_w [NUM_CH]; // Channel input levels

  assign level_w[0] = level_left_hdb;
  assign level_w[1] = level_right_hdb;

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_chan
    rac_agc_chan #(
      .CYC_PER_MS(CYC_PER_MS)
    ) u_chan (
      .ref_clk(ref_clk),
      .rst_n(rst_sync_q),
      .ctrl_a(ctrl_q[ch * REGS_PER_CH]),
      .ctrl_b(ctrl_q[ch * REGS_PER_CH + 1]),
      .ctrl_c(ctrl_q[ch * REGS_PER_CH + 2]),
      .dra_en(dra_en),
      .level_hdb(level_w[ch]),
      .gain_hdb(gain_w[ch]),
      .sat(sat_w[ch])
    );
  end

  assign gain_left_hdb = gain_w[0];
  assign gain_right_hdb = gain_w[1];
  assign sat_left = sat_w[0];
  assign sat_right = sat_w[1];

  ////////////////////////////////////////////////////////////////////////////
  // Check helpers: the whole bank side by side, and the slot under the address
  localparam int REG_W = 8; // Control register width
  logic [NUM_CTRL*REG_W-1:0] ctrl_flat; // Every control register, slot 0 lowest
  logic [7:0] ctrl_sel; // Control register at the current address

  for (genvar i = 0; i < NUM_CTRL; i++)
  begin : g_flat
    assign ctrl_flat[i * REG_W +: REG_W] = ctrl_q[i];
  end

  // Guarded so an off-map address never indexes past the array
  assign ctrl_sel = (wr_idx < NUM_CTRL) ? ctrl_q[wr_idx] : RD_UNMAPPED;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_q);

  sequence s_write_right_b;
    reg_wr && reg_addr == ADDR_RIGHT_B;
  endsequence

  // Write to the left control A slot
  sequence s_write_left_a;
    reg_wr && reg_addr == ADDR_LEFT_A;
  endsequence

  // Write that lands on no control register, read-only gains included
  sequence s_write_off_map;
    reg_wr && wr_idx >= NUM_CTRL;
  endsequence

  // Writes land in their own slot and nowhere else
  chk_right_write: assert property (s_write_right_b |=>
    ctrl_q[4] == $past(reg_wdata) && $stable(ctrl_q[1]))
    else $error("right write lost or leaked to left");
  chk_left_write: assert property (s_write_left_a |=>
    ctrl_q[0] == $past(reg_wdata) && $stable(ctrl_q[3]))
    else $error("left write lost or leaked to right");
  chk_off_map_write: assert property (s_write_off_map |=> $stable(ctrl_flat))
    else $error("write off the map changed a control register");

  // Reads return what stood under the address one edge earlier
  chk_ctrl_readback: assert property ((wr_idx < NUM_CTRL) |=>
    reg_rdata == $past(ctrl_sel))
    else $error("control register readback wrong");
  chk_gain_readback: assert property ((reg_addr == ADDR_GAIN_LEFT) |=>
    reg_rdata == $past(gain_left_hdb))
    else $error("left gain readback wrong");
  chk_right_readback: assert property ((reg_addr == ADDR_GAIN_RIGHT) |=>
    reg_rdata == $past(gain_right_hdb))
    else $error("right gain readback wrong");
  chk_off_map_read: assert property ((wr_idx >= NUM_CTRL && reg_addr != ADDR_GAIN_LEFT
    && reg_addr != ADDR_GAIN_RIGHT) |=> reg_rdata == RD_UNMAPPED)
    else $error("unmapped read not zero");

endmodule

// *** testbench/rac_regs_test.sv ***
// Self-checking bench for the record AGC register bank and both channels.
module rac_regs_test
  import rac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Settings and tables worked out from the register descriptions
  localparam int CPM = 32; // Short ms keeps the slow constants affordable
  localparam int CYC = CPM / 16; // Step-interval cycles per ms of a time constant
  int atk_tab [4] = '{8, 11, 16, 20}; // Attack ms per code
  int dec_tab [4] = '{100, 200, 400, 500}; // Decay ms per code
  int tgt_tab [8] = '{-11, -16, -20, -24, -28, -34, -40, -48}; // Half-dB
  int hys_tab [4] = '{2, 4, 6, 0}; // Hysteresis half-dB per code

  typedef struct {int sel; int lo; int hi;} rac_note_t; // One expected result

  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic dra_en = 1'b0;
  logic signed [9:0] lvl [2] = '{10'h000, 10'h000}; // Channel input levels
  logic signed [7:0] gain_left_hdb;
  logic signed [7:0] gain_right_hdb;
  logic sat_left;
  logic sat_right;
  logic chk_pend = 1'b0; // A result is due at the next edge
  rac_note_t notes [$]; // Expected results, oldest first
  rac_note_t note;
  logic signed [9:0] val;
  logic [7:0] wd [6];
  int seed = 32'h9AF7;
  int errors = 0;
  int cmp_count = 0;

  rac_regs #(.CYC_PER_MS(CPM)) uut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .dra_en(dra_en),
    .level_left_hdb(lvl[0]),
    .level_right_hdb(lvl[1]),
    .gain_left_hdb(gain_left_hdb),
    .gain_right_hdb(gain_right_hdb),
    .sat_left(sat_left),
    .sat_right(sat_right)
  );

  // 20 MHz core clock
  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and check helpers

  // Control register address of a channel, field k = A, B, C
  function automatic logic [7:0] ra(input int ch, input int k);
    return 8'(int'(ADDR_LEFT_A) + 3 * ch + k);
  endfunction

  // Applied gain register of a channel
  function automatic logic [7:0] ga(input int ch);
    return (ch == 1) ? ADDR_GAIN_RIGHT : ADDR_GAIN_LEFT;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Present an address and note the range expected one edge later
  task automatic chk(input int sel, input logic [7:0] a, input int lo, input int hi);
    rac_note_t n;
    n = '{sel, lo, hi};
    @(posedge ref_clk);
    reg_addr <= a;
    chk_pend <= 1'b1;
    notes.push_back(n);
    @(posedge ref_clk);
    chk_pend <= 1'b0;
  endtask

  task automatic setl(input int ch, input int v);
    @(posedge ref_clk);
    lvl[ch] <= 10'(v);
  endtask

  // Restart one channel with fresh settings; the other is parked disabled
  task automatic run(input int ch, input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] c, input int lv, input int n, input int lo, input int hi);
    wr(ra(1 - ch, 0), 8'h00);
    wr(ra(ch, 0), 8'h00);
    lvl[ch] <= 10'(lv);
    lvl[1 - ch] <= 10'($random(seed));
    wr(ra(ch, 1), b);
    wr(ra(ch, 2), c);
    wr(ra(ch, 0), a);
    cyc(n);
    chk(3, ga(ch), lo, hi);
    chk(3, ga(1 - ch), 0, 0);
  endtask

  task automatic done(input string s);
    $display("Test %s finished at %0t", s, $time);
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: takes the oldest note whenever a result is due
  always @(posedge ref_clk)
  begin
    if (chk_pend)
    begin
      #1;
      note = notes.pop_front();
      // Pick the watched output; reads are unsigned unless they hold gain
      case (note.sel)
        0: val = $signed({2'b00, reg_rdata});
        1: val = {9'h000, sat_left};
        2: val = {9'h000, sat_right};
        3: val = $signed(reg_rdata);
        4: val = gain_left_hdb;
        default: val = gain_right_hdb;
      endcase
      cmp_count++;
      if ($isunknown(val) || val < note.lo || val > note.hi)
      begin
        errors++;
        $display("Error at %0t: sel %0d got %0d, want %0d..%0d", $time, note.sel, val,
          note.lo, note.hi);
      end
    end
  end

  // Watchdog sized well above the longest expected run
  initial
  begin
    cyc(90000);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(4);
    resetn <= 1'b1;
    cyc(3);
    for (int k = 0; k < 6; k++)
      chk(0, ra(k / 3, k % 3), (k % 3 == 1) ? 254 : 0, (k % 3 == 1) ? 254 : 0);
    chk(3, ga(0), 0, 0);
    chk(3, ga(1), 0, 0);
    chk(1, 8'h00, 0, 0);
    chk(2, 8'h00, 0, 0);
    done("reset");
    // Random read-back; enable held off and reserved bit kept zero
    for (int k = 0; k < 6; k++)
    begin
      wd[k] = 8'($random(seed));
      if (k % 3 == 0)
        wd[k][7] = 1'b0;
      if (k % 3 == 1)
        wd[k][0] = 1'b0;
      wr(ra(k / 3, k % 3), wd[k]);
    end
    wr(8'h22, 8'hFF);
    wr(ADDR_GAIN_LEFT, 8'h5A);
    for (int k = 0; k < 6; k++)
      chk(0, ra(k / 3, k % 3), int'(wd[k]), int'(wd[k]));
    chk(0, 8'h22, 0, 0);
    chk(3, ADDR_GAIN_LEFT, 0, 0);
    done("readback");
    // Level one step off each target: one step, then rest at the target
    for (int ch = 0; ch < 2; ch++)
      for (int t = 0; t < 8; t++)
      begin
        run(ch, 8'(8'h80 + t * 16), 8'hFE, 8'h00, tgt_tab[t] + 1, 40, -1, -1);
        run(ch, 8'(8'h80 + t * 16), 8'hFE, 8'h00, tgt_tab[t] - 1, 500, 1, 1);
      end
    done("targets");
    // Three and a half step intervals give exactly three steps
    for (int ch = 0; ch < 2; ch++)
      for (int k = 0; k < 4; k++)
      begin
        run(ch, 8'(8'h80 + k * 4), 8'hFE, 8'h00, 0, atk_tab[k] * CYC * 7 / 2, -3, -3);
        run(ch, 8'(8'h80 + k), 8'hFE, 8'h00, -40, dec_tab[k] * CYC * 7 / 2, 3, 3);
      end
    done("times");
    // Gate set below threshold, held inside the hysteresis band
    for (int h = 0; h < 4; h++)
    begin
      run(0, 8'h80, 8'hFE, 8'(h * 64 + 2), -61, 300, 0, 0);
      setl(0, -60 + hys_tab[h]);
      cyc(300);
      chk(3, ga(0), 0, 0);
      setl(0, -59 + hys_tab[h]);
      cyc(210);
      chk(3, ga(0), 1, 2);
    end
    run(1, 8'h80, 8'hFE, 8'h3E, -181, 300, 0, 0);
    run(1, 8'h80, 8'hFE, 8'h3E, -170, 300, 1, 1);
    run(1, 8'h80, 8'hFE, 8'h02, -59, 300, 1, 1);
    run(1, 8'h80, 8'hFE, 8'h00, -300, 300, 1, 1);
    done("gate");
    // Clip stepping pulls gain down each edge until below full scale
    run(0, 8'h8F, 8'hFE, 8'h01, 10, 30, -12, -11);
    run(0, 8'h8F, 8'hFE, 8'h00, 10, 30, 0, 0);
    done("clip");
    // Ramp to the ceiling at double rate, then move the ceiling
    dra_en <= 1'b1;
    for (int ch = 0; ch < 2; ch++)
    begin
      run(ch, 8'h80, 8'hFE, 8'h00, -300, 12100, 119, 119);
      chk(1 + ch, 8'h00, 1, 1);
      chk(2 - ch, 8'h00, 0, 0);
      wr(ra(ch, 1), 8'hF0);
      chk(3, ga(ch), 119, 119);
      chk(1 + ch, 8'h00, 1, 1);
      wr(ra(ch, 1), 8'hEC);
      cyc(2);
      chk(4 + ch, 8'h00, 118, 118);
      chk(1 + ch, 8'h00, 1, 1);
    end
    done("ceiling");
    cyc(3);
    stop_test();
  end
endmodule
